// File: hw/codec_power_mute_control.sv
// codec control register with power-down, soft reset, mute and channel select
// assumes an APB master on CORE_CLK and serial pins from another clock domain
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - setting interface power-down powers down the digital interface and the filter/codec; clear (default) keeps it active.
// - setting driver power-down powers down the ear driver and the filter/codec.
// - in stream mode with driver power-down set, the selected output channel is high impedance.
// - in strobed mode with driver power-down set, the zero code is driven throughout each valid strobe.
// - in strobed mode with driver power-down set, the output is high impedance outside the strobe.
// - setting soft reset returns every register to default like a hardware reset, keeping the reset bit set and the device powered.
// - soft reset ends only by writing the bit low or by the hardware reset, never by itself.
// - transmit mute replaces the outgoing stream with the quiet code while the transmit path keeps running.
// - receive mute replaces the incoming stream with the quiet code.
// - in stream mode received voice comes from channel B2 when receive select is set, else B1; no effect in strobed mode.
// - in stream mode voice is sent on channel B2 when transmit select is set, else B1; unused in strobed mode.
module codec_power_mute_control #(
    parameter logic [7:0] QUIET_CODE = 8'hff,
    parameter logic [7:0] ZERO_CODE = 8'hff,
    parameter logic [4:0] B1_SLOT = 5'h02,
    parameter logic [4:0] B2_SLOT = 5'h03
) (
    // clock and hardware reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // transmit words from the filter/codec
    input wire logic [7:0] TX_PCM_DATA,
    input wire logic TX_PCM_VALID,
    output logic TX_PCM_READY,
    // received words toward the filter/codec
    output logic [7:0] RX_PCM_DATA,
    output logic RX_PCM_VALID,
    // serial pcm pins
    input wire logic BIT_CLK,
    input wire logic FRAME_STROBE,
    input wire logic PCM_IN,
    input wire logic TDM_MODE,
    output logic PCM_OUT,
    output logic PCM_OUT_OE_N,
    // power-down controls
    output logic IFACE_PWRDN,
    output logic DRIVER_PWRDN,
    output logic CODEC_PWRDN
);
    logic [7:0] ctrl_ff;
    logic iface_pd;
    logic driver_pd;
    logic soft_rst;
    logic tx_mute;
    logic rx_mute;
    logic tx_sel;
    logic rx_sel;
    logic dp_run;
    logic apb_access;
    logic do_write;
    logic hit_ctrl;
    logic hit_status;
    logic [7:0] status_val;
    logic [3:0] pin_s;
    logic bclk_s;
    logic fs_s;
    logic pcm_in_s;
    logic tdm_s;
    logic bclk_last_ff;
    logic fs_last_ff;
    logic bclk_rise;
    logic frame_start;
    logic [7:0] pos_ff;
    logic [7:0] cur_pos;
    logic [2:0] bit_idx;
    logic [4:0] tx_slot;
    logic [4:0] rx_slot;
    logic tx_win;
    logic rx_win;
    logic tx_load;
    logic [7:0] buf_data;
    logic buf_valid;
    logic [7:0] tx_word;
    logic [7:0] tx_shift_ff;
    logic [7:0] rx_shift_ff;

    // control fields
    assign iface_pd = ctrl_ff[codec_ctrl_pkg::BIT_IFACE_PD];
    assign driver_pd = ctrl_ff[codec_ctrl_pkg::BIT_DRIVER_PD];
    assign soft_rst = ctrl_ff[codec_ctrl_pkg::BIT_SOFT_RST];
    assign tx_mute = ctrl_ff[codec_ctrl_pkg::BIT_TX_MUTE];
    assign rx_mute = ctrl_ff[codec_ctrl_pkg::BIT_RX_MUTE];
    assign tx_sel = ctrl_ff[codec_ctrl_pkg::BIT_TX_SEL];
    assign rx_sel = ctrl_ff[codec_ctrl_pkg::BIT_RX_SEL];
    assign dp_run = !iface_pd && !soft_rst;

    // apb decode: one wait state, write lands on the pready edge
    assign apb_access = PSEL && PENABLE && !PREADY;
    assign do_write = PSEL && PENABLE && PREADY && PWRITE;
    assign hit_ctrl = (PADDR == codec_ctrl_pkg::CTRL_ADDR);
    assign hit_status = (PADDR == codec_ctrl_pkg::STATUS_ADDR);

    // status word showing live block state
    always_comb begin
        status_val = 8'h00;
        status_val[codec_ctrl_pkg::ST_IFACE_ACTIVE] = !iface_pd;
        status_val[codec_ctrl_pkg::ST_DRIVER_ACTIVE] = !iface_pd && !driver_pd;
        status_val[codec_ctrl_pkg::ST_SOFT_RST] = soft_rst;
        status_val[codec_ctrl_pkg::ST_TX_BUF_VALID] = buf_valid;
        status_val[codec_ctrl_pkg::ST_TDM_MODE] = tdm_s;
    end

    // apb answer: ready, read data and error on unmapped addresses
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= apb_access;
            if (apb_access) begin
                PSLVERR <= !(hit_ctrl || hit_status);
                if (PWRITE) begin
                    PRDATA <= 32'h0000_0000;
                end else if (hit_ctrl) begin
                    PRDATA <= {24'h00_0000, ctrl_ff};
                end else if (hit_status) begin
                    PRDATA <= {24'h00_0000, status_val};
                end else begin
                    PRDATA <= 32'h0000_0000;
                end
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end

    // control register; the hardware reset also ends a soft reset
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_ff <= codec_ctrl_pkg::CTRL_RESET;
        end else if (do_write && hit_ctrl && PSTRB[0]) begin
            if (PWDATA[codec_ctrl_pkg::BIT_SOFT_RST]) begin
                ctrl_ff <= codec_ctrl_pkg::CTRL_SOFT_RST_VALUE;
            end else begin
                // released by write / unused bit dropped
                ctrl_ff <= PWDATA[7:0] & codec_ctrl_pkg::CTRL_WRITE_MASK;
            end
        end
    end

    // power-down outputs; soft reset keeps the device powered
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            IFACE_PWRDN <= 1'b0;
            DRIVER_PWRDN <= 1'b0;
            CODEC_PWRDN <= 1'b0;
        end else begin
            IFACE_PWRDN <= iface_pd && !soft_rst;
            DRIVER_PWRDN <= driver_pd && !soft_rst;
            CODEC_PWRDN <= (iface_pd || driver_pd) && !soft_rst;
        end
    end

    // serial pins cross into the core clock
    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .async_in({TDM_MODE, PCM_IN, FRAME_STROBE, BIT_CLK}),
        .sync_out(pin_s)
    );
    assign bclk_s = pin_s[0];
    assign fs_s = pin_s[1];
    assign pcm_in_s = pin_s[2];
    assign tdm_s = pin_s[3];

    // bit clock edge and frame or strobe start
    assign bclk_rise = bclk_s && !bclk_last_ff;
    assign frame_start = tdm_s ? fs_s : (fs_s && !fs_last_ff);
    assign cur_pos = frame_start ? 8'h00 : pos_ff;
    assign bit_idx = cur_pos[2:0];
    assign tx_slot = tx_sel ? B2_SLOT : B1_SLOT;
    assign rx_slot = rx_sel ? B2_SLOT : B1_SLOT;
    assign tx_win = tdm_s ? (cur_pos[7:3] == tx_slot) : (fs_s && cur_pos[7:3] == 5'h00);
    assign rx_win = tdm_s ? (cur_pos[7:3] == rx_slot) : (fs_s && cur_pos[7:3] == 5'h00);
    assign tx_load = bclk_rise && tx_win && (bit_idx == 3'h0) && dp_run;

    // bit position within the frame or strobe
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bclk_last_ff <= 1'b0;
            fs_last_ff <= 1'b0;
            // no frame seen yet: park outside every slot so stray bit edges send nothing
            pos_ff <= codec_ctrl_pkg::POS_MAX;
        end else begin
            bclk_last_ff <= bclk_s;
            if (!dp_run) begin
                pos_ff <= codec_ctrl_pkg::POS_MAX;
                fs_last_ff <= 1'b0;
            end else if (bclk_rise) begin
                fs_last_ff <= fs_s;
                pos_ff <= (cur_pos == codec_ctrl_pkg::POS_MAX) ? cur_pos : cur_pos + 8'h01;
            end
        end
    end

    // transmit words wait here until their slot comes round
    pcm_buffer #(
        .WIDTH(codec_ctrl_pkg::PCM_BITS),
        .DEPTH(codec_ctrl_pkg::TX_BUF_DEPTH)
    ) u_tx_buffer (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .clr(!dp_run),
        .s_data(TX_PCM_DATA),
        .s_valid(TX_PCM_VALID),
        .s_ready(TX_PCM_READY),
        .m_data(buf_data),
        .m_valid(buf_valid),
        .m_ready(tx_load)
    );

    // choose the word sent in the slot; an empty buffer sends quiet code unless the driver is down in strobed mode
    always_comb begin
        if (driver_pd && !tdm_s) begin
            tx_word = ZERO_CODE;
        end else if (tx_mute || !buf_valid) begin
            tx_word = QUIET_CODE;
        end else begin
            tx_word = buf_data;
        end
    end

    // serial output, msb first, enable low while driving
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PCM_OUT <= 1'b0;
            PCM_OUT_OE_N <= 1'b1;
            tx_shift_ff <= 8'h00;
        end else if (!dp_run) begin
            PCM_OUT_OE_N <= 1'b1; // pins released
        end else if (!tdm_s && !fs_s) begin
            PCM_OUT_OE_N <= 1'b1;
        end else if (bclk_rise) begin
            PCM_OUT_OE_N <= !(tx_win && !(tdm_s && driver_pd));
            if (tx_load) begin
                PCM_OUT <= tx_word[7];
                tx_shift_ff <= {tx_word[6:0], 1'b0};
            end else if (tx_win) begin
                PCM_OUT <= tx_shift_ff[7];
                tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
            end
        end
    end

    // receive deserialiser; a word appears as a one-cycle pulse
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_shift_ff <= 8'h00;
            RX_PCM_DATA <= 8'h00;
            RX_PCM_VALID <= 1'b0;
        end else begin
            RX_PCM_VALID <= 1'b0;
            if (!dp_run) begin
                rx_shift_ff <= 8'h00;
            end else if (bclk_rise && rx_win) begin
                rx_shift_ff <= {rx_shift_ff[6:0], pcm_in_s};
                if (bit_idx == codec_ctrl_pkg::LAST_BIT) begin
                    RX_PCM_VALID <= 1'b1;
                    RX_PCM_DATA <= rx_mute ? QUIET_CODE : {rx_shift_ff[6:0], pcm_in_s};
                end
            end
        end
    end
endmodule : codec_power_mute_control
`default_nettype wire

// File: hw/pcm_buffer.sv
// small fifo with valid/ready on both sides and a synchronous flush
// assumes filler and drainer share the clock
`timescale 1ns/1ps
`default_nettype none
module pcm_buffer #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    // clock, reset, flush
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    // filling side
    input wire logic [WIDTH-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready,
    // draining side
    output logic [WIDTH-1:0] m_data,
    output logic m_valid,
    input wire logic m_ready
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic [PW:0] nxt_count;
    logic push;
    logic pop;

    // handshakes and occupancy
    assign push = s_valid & s_ready;
    assign pop = m_valid & m_ready;
    assign m_valid = (count_ff != '0);
    assign m_data = mem[rd_ptr_ff];
    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    // pointers, count and a registered ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            s_ready <= 1'b0;
        end else if (clr) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            s_ready <= 1'b0; // held off while flushing
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= nxt_count;
            s_ready <= (nxt_count != FULL);
        end
    end

    // storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= s_data;
        end
    end
endmodule : pcm_buffer
`default_nettype wire

// File: hw/pin_sync.sv
// two-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level or is sampled well above its toggle rate
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous inputs and their synchronised copies
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : pin_sync
`default_nettype wire

// File: shared/codec_ctrl_pkg.sv
// constants of the codec power, mute and channel control block
// assumes a 32-bit APB slave with word-aligned registers
package codec_ctrl_pkg;
    // register indices and their byte addresses (index times four)
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] CTRL_INDEX = 8'h03;
    localparam logic [7:0] STATUS_INDEX = 8'h04;
    localparam logic [7:0] CTRL_ADDR = {CTRL_INDEX[5:0], 2'b00};
    localparam logic [7:0] STATUS_ADDR = {STATUS_INDEX[5:0], 2'b00};
    // control register field positions
    localparam int unsigned BIT_IFACE_PD = 7;
    localparam int unsigned BIT_DRIVER_PD = 6;
    localparam int unsigned BIT_SOFT_RST = 5;
    localparam int unsigned BIT_UNUSED = 4;
    localparam int unsigned BIT_TX_MUTE = 3;
    localparam int unsigned BIT_RX_MUTE = 2;
    localparam int unsigned BIT_TX_SEL = 1;
    localparam int unsigned BIT_RX_SEL = 0;
    // control register values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hef;
    localparam logic [7:0] CTRL_SOFT_RST_VALUE = 8'h20;
    // status register field positions
    localparam int unsigned ST_IFACE_ACTIVE = 0;
    localparam int unsigned ST_DRIVER_ACTIVE = 1;
    localparam int unsigned ST_SOFT_RST = 2;
    localparam int unsigned ST_TX_BUF_VALID = 3;
    localparam int unsigned ST_TDM_MODE = 4;
    // serial framing
    localparam int unsigned PCM_BITS = 8;
    localparam int unsigned POS_W = 8;
    localparam int unsigned SLOT_W = 5;
    localparam logic [7:0] POS_MAX = 8'hff;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int unsigned TX_BUF_DEPTH = 2;
endpackage : codec_ctrl_pkg

// File: verif/codec_ctrl_chk.sv
// port checks for the codec control block
// assumes binding onto the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_chk (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // stream and pins
    input wire logic TX_PCM_READY,
    input wire logic FRAME_STROBE,
    input wire logic TDM_MODE,
    input wire logic PCM_OUT_OE_N,
    // power-down
    input wire logic IFACE_PWRDN,
    input wire logic DRIVER_PWRDN,
    input wire logic CODEC_PWRDN
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] pd_cnt_ff;
    // counts cycles in stream mode with the driver down
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) pd_cnt_ff <= 8'h00;
        else if (!(DRIVER_PWRDN && TDM_MODE)) pd_cnt_ff <= 8'h00;
        else if (pd_cnt_ff != 8'hff) pd_cnt_ff <= pd_cnt_ff + 8'h01;
    end
    // apb phases
    sequence s_wait;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_ctrl_wr;
        PSEL && PENABLE && PREADY && PWRITE && PADDR == codec_ctrl_pkg::CTRL_ADDR && PSTRB[0];
    endsequence
    AST_ONE_WAIT: assert property (s_wait |=> PREADY)
        else $error("no answer after one wait");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("pready held too long");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("pslverr without pready");
    AST_UNUSED_ZERO:
        assert property (PREADY && !PWRITE && PADDR == codec_ctrl_pkg::CTRL_ADDR |-> PRDATA[31:8] == 24'h0 && !PRDATA[4])
        else $error("unused control bit not zero");
    AST_CODEC_PD: assert property (CODEC_PWRDN == (IFACE_PWRDN || DRIVER_PWRDN))
        else $error("codec power-down wrong");
    AST_IFACE_PD_SET: assert property (s_ctrl_wr ##0 (PWDATA[7] && !PWDATA[5]) |-> ##[1:3] IFACE_PWRDN)
        else $error("interface not powered down");
    AST_SOFT_RST_IDLE:
        assert property (s_ctrl_wr ##0 PWDATA[5] |-> ##3 (!CODEC_PWRDN && PCM_OUT_OE_N && !TX_PCM_READY))
        else $error("soft reset not idle");
    AST_IFACE_PD_STOP: assert property (IFACE_PWRDN && $past(IFACE_PWRDN) |-> !TX_PCM_READY)
        else $error("stream taken while powered down");
    AST_STREAM_PD_HIZ: assert property (pd_cnt_ff >= 8'hc0 |-> PCM_OUT_OE_N)
        else $error("output driven with driver down");
    AST_STROBE_GAP_HIZ: assert property ((!TDM_MODE && !FRAME_STROBE) [*5] |-> PCM_OUT_OE_N)
        else $error("output driven outside strobe");
endmodule : codec_ctrl_chk
bind codec_power_mute_control codec_ctrl_chk codec_ctrl_chk_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_PCM_READY(TX_PCM_READY), .FRAME_STROBE(FRAME_STROBE), .TDM_MODE(TDM_MODE),
    .PCM_OUT_OE_N(PCM_OUT_OE_N), .IFACE_PWRDN(IFACE_PWRDN), .DRIVER_PWRDN(DRIVER_PWRDN),
    .CODEC_PWRDN(CODEC_PWRDN)
);
`default_nettype wire

// File: verif/host_apb_model.sv
// apb master standing for the host controller
// assumes one clock; waits for pready, a hang is cut by the bench watchdog
`timescale 1ns/1ps
`default_nettype none
module host_apb_model (
    // clock
    input wire logic clk,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // answer
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // setup, then access held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rdat, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : host_apb_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the codec control block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] QUIET = 8'h7f;
    localparam logic [7:0] ZERO = 8'hd5;
    localparam logic [7:0] CTRL = codec_ctrl_pkg::CTRL_ADDR;
    localparam logic [7:0] STAT = codec_ctrl_pkg::STATUS_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, rx_data, ctrl_m;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic bit_clk = 1'b0;
    logic fs = 1'b0;
    logic pcm_in = 1'b0;
    logic tdm = 1'b1;
    logic tx_ready, rx_valid, pcm_out, oe_n, iface_pd, drv_pd, codec_pd;
    logic [31:0] seed = 32'he7b7;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    int fails = 0;
    int checked = 0;
    // block with distinct quiet and zero codes
    codec_power_mute_control #(.QUIET_CODE(QUIET), .ZERO_CODE(ZERO)) codec_power_mute_control_inst (
        .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TX_PCM_DATA(tx_data), .TX_PCM_VALID(tx_valid), .TX_PCM_READY(tx_ready), .RX_PCM_DATA(rx_data),
        .RX_PCM_VALID(rx_valid), .BIT_CLK(bit_clk), .FRAME_STROBE(fs), .PCM_IN(pcm_in), .TDM_MODE(tdm),
        .PCM_OUT(pcm_out), .PCM_OUT_OE_N(oe_n), .IFACE_PWRDN(iface_pd), .DRIVER_PWRDN(drv_pd),
        .CODEC_PWRDN(codec_pd)
    );
    // host side
    host_apb_model host_apb_model_inst (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr)
    );
    // clock and received-word capture
    always #2.5 clk = ~clk;
    always @(posedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        host_apb_model_inst.xfer(1'b1, a, d, s, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host_apb_model_inst.xfer(1'b0, a, 32'h0, 4'hf, r, e);
    endtask : rd
    // offer one transmit word until taken
    task automatic push(input logic [7:0] w);
        @(posedge clk);
        tx_data <= w;
        tx_valid <= 1'b1;
        do begin
            @(posedge clk);
        end while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
        tx_data <= ~w;
    endtask : push
    // one frame of 32 bit edges, checking the output each edge
    task automatic frame(input logic [7:0] cfg, input logic [7:0] rxw, input logic [7:0] txw);
        int lo, rlo;
        logic want;
        lo = !tdm ? 0 : cfg[1] ? 24 : 16;
        rlo = !tdm ? 0 : cfg[0] ? 24 : 16;
        for (int p = 0; p < 32; p++) begin
            seed = lfsr(seed);
            fs <= tdm ? (p == 0) : (p < 8);
            pcm_in <= (p >= rlo && p < rlo + 8) ? rxw[rlo + 7 - p] : seed[0];
            repeat (8) @(posedge clk);
            bit_clk <= 1'b1;
            repeat (7) @(posedge clk);
            @(negedge clk);
            want = p >= lo && p < lo + 8 && !(tdm && cfg[6]);
            chk({31'h0, oe_n}, {31'h0, !want});
            if (want) chk({31'h0, pcm_out}, {31'h0, txw[lo + 7 - p]});
            @(posedge clk);
            bit_clk <= 1'b0;
        end
        fs <= 1'b0;
    endtask : frame
    // configure, load n words, run a frame, check both ways
    task automatic ser(input logic mode, input logic [7:0] cfg, input int n);
        logic [7:0] w, rxw;
        wr(CTRL, 32'h20, 4'h1);
        wr(CTRL, {24'h0, cfg}, 4'h1);
        tdm <= mode;
        txq.delete();
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            push(seed[7:0]);
            txq.push_back(seed[7:0]);
        end
        repeat (2) @(posedge clk);
        if (n == 2) chk({31'h0, tx_ready}, 32'h0);
        w = (cfg[3] || txq.size() == 0) ? QUIET : txq[0];
        if (!mode && cfg[6]) w = ZERO;
        rxw = seed[15:8];
        rxq.delete();
        frame(cfg, rxw, w);
        repeat (20) @(posedge clk);
        if (!cfg[6]) chk(32'(rxq.size()), 32'h1);
        if (!cfg[6] && rxq.size() > 0) chk({24'h0, rxq[0]}, {24'h0, cfg[2] ? QUIET : rxw});
        $display("serial test mode %0d cfg %h done", mode, cfg);
    endtask : ser
    // main sequence
    initial begin
        logic [7:0] v;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(CTRL);
        chk(r, 32'h0);
        rd(STAT);
        chk(r, 32'h13);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h10 : (i == 2) ? 8'h80 : seed[7:0];
            wr(CTRL, {seed[31:8], v}, 4'h1);
            ctrl_m = v[5] ? 8'h20 : v & 8'hef;
            repeat (3) @(posedge clk);
            chk({29'h0, iface_pd, drv_pd, codec_pd}, {29'h0, ctrl_m[7:6], |ctrl_m[7:6]});
            rd(CTRL);
            chk(r, {24'h0, ctrl_m});
        end
        wr(CTRL, 32'hff, 4'h1);
        repeat (50) @(posedge clk);
        rd(STAT);
        chk(r, 32'h17);
        // hardware reset in mid-run must also end the soft reset
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(CTRL);
        chk(r, 32'h0);
        rd(STAT);
        chk(r, 32'h13);
        wr(CTRL, 32'h0, 4'h1);
        wr(CTRL, 32'hc0, 4'he);
        rd(CTRL);
        chk(r, 32'h0);
        wr(8'h40, 32'hc0, 4'hf);
        chk({31'h0, e}, 32'h1);
        rd(8'h40);
        chk({r[30:0], e}, 32'h1);
        wr(STAT, 32'hff, 4'hf);
        chk({31'h0, e}, 32'h0);
        $display("register test done");
        ser(1'b1, 8'h00, 2);
        rd(STAT);
        chk(r, 32'h1b);
        ser(1'b1, 8'h03, 1);
        ser(1'b1, 8'h0c, 1);
        ser(1'b1, 8'h00, 0);
        ser(1'b1, 8'h40, 1);
        ser(1'b0, 8'h03, 1);
        ser(1'b0, 8'h40, 0);
        tally_and_finish();
    end
    // cuts a hang short
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
